// File: verilog/i2c_cfg_consts.vh
// Purpose: constants of the two-wire role and target configuration block
// Assumes: 32-bit APB byte addresses, one aligned word per register
// Notes: definitions only
`ifndef I2C_CFG_CONSTS_VH
`define I2C_CFG_CONSTS_VH

`define ADDR_CFG 32'h50001300
`define ADDR_TAR 32'h50001304
`define ADDR_SAR 32'h50001308
`define ADDR_CMD 32'h50001310
`define ADDR_STAT 32'h50001334
`define ADDR_ON 32'h5000136c

`define CFG_SLV_DIS 6
`define CFG_RESTART 5
`define CFG_MWIDE 4
`define CFG_SWIDE 3
`define CFG_SPD_HI 2
`define CFG_SPD_LO 1
`define CFG_MEN 0
`define CFG_MASK 16'h007f
`define CFG_RST 16'h007d

`define TAR_SPECIAL 11
`define TAR_PICK 10
`define TAR_MASK 16'h0fff
`define TAR_RST 16'h0055
`define SAR_RST 10'h055

`define CMD_READ 8
`define STAT_BUSY 0
`define STAT_GC 1
`define STAT_LOOP 2
`define STAT_ABORT 6

`define SPEED_STD 2'h1
`define SPEED_FAST 2'h2
`define GC_ADDR 8'h00
`define START_BYTE 8'h01
`define WIDE_PREFIX 5'h1e

`endif

// File: verilog/sync_two_flop.v
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to clock
// Notes: first stage is read only by the second
`timescale 1ns/1ns
module sync_two_flop #(
  parameter W = 2
) (
  input wire clock,
  input wire arst_n,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] stage1;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      // pins idle high, so reset to that level to avoid a false edge
      stage1 <= {W{1'b1}};
      dout <= {W{1'b1}};
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

// File: verilog/addr_header_gen.v
// Purpose: forms the address bytes a master transfer begins with
// Assumes: target and mode bits are stable while sampled
// Notes: purely combinational; the caller registers the result
`timescale 1ns/1ns
`include "i2c_cfg_consts.vh"
module addr_header_gen (
  input wire [9:0] target,
  input wire wide,
  input wire special,
  input wire pick,
  input wire read,
  output reg [7:0] firstByte,
  output reg [7:0] secondByte,
  output reg twoBytes,
  output reg startBytePre
);
  always @* begin
    firstByte = {target[6:0], read};
    secondByte = 8'h00;
    twoBytes = 1'b0;
    startBytePre = special & pick;
    if (special && !pick) begin
      // general call ignores the target bits
      firstByte = `GC_ADDR;
    end else if (wide) begin
      firstByte = {`WIDE_PREFIX, target[9:8], read};
      secondByte = target[7:0];
      twoBytes = 1'b1;
    end
  end
endmodule

// File: verilog/i2c_role_target_cfg.v
// Purpose: role, speed and target configuration of a two-wire controller
// Assumes: APB master on clock; scl and sda pins are asynchronous
// Notes: every output is registered; apb answers after one wait state
//
// Implementation choice: the APB register port.
`timescale 1ns/1ns
`include "i2c_cfg_consts.vh"
module i2c_role_target_cfg (
  input wire clock,
  input wire arst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire sclIn,
  input wire sdaIn,
  output reg masterEnable,
  output reg slaveEnable,
  output reg restartEnable,
  output reg initiatorWide,
  output reg responderWide,
  output reg speedStd,
  output reg speedFast,
  output reg [9:0] ownAddress,
  output reg cmdValid,
  output reg cmdRead,
  output reg [7:0] cmdData,
  output reg [7:0] headerFirst,
  output reg [7:0] headerSecond,
  output reg headerTwoBytes,
  output reg headerStartByte,
  output reg busBusy
);
  reg [15:0] roleCfg;
  reg [15:0] target;
  reg [9:0] ownResponderAddress;
  reg controllerOnSwitch;
  reg transmitAbortFlag;
  reg gcMode;
  reg loopDirSet;
  reg loopDir;
  reg sclPrev;
  reg sdaPrev;
  wire [1:0] pinSync;
  wire sclNow;
  wire sdaNow;
  wire [7:0] genFirst;
  wire [7:0] genSecond;
  wire genTwo;
  wire genStart;
  wire apbDone;
  wire wrDone;
  wire hitCfg;
  wire hitTar;
  wire hitSar;
  wire hitCmd;
  wire hitStat;
  wire hitOn;
  wire mapped;
  wire special;
  wire pick;
  wire gcNow;
  wire cmdIsRead;
  wire selfTarget;
  wire loopback;
  wire abortGc;
  wire abortLoop;
  wire abortSelf;
  wire cmdPush;
  wire cmdAbort;
  wire abortClr;
  wire startSeen;
  wire stopSeen;
  reg [31:0] next_prdata;

  sync_two_flop #(
    .W(2)
  ) u_pin_sync (
    .clock(clock),
    .arst_n(arst_n),
    .din({sclIn, sdaIn}),
    .dout(pinSync)
  );

  assign sclNow = pinSync[1];
  assign sdaNow = pinSync[0];

  addr_header_gen u_header (
    .target(target[9:0]),
    .wide(roleCfg[`CFG_MWIDE]),
    .special(special),
    .pick(pick),
    .read(cmdIsRead),
    .firstByte(genFirst),
    .secondByte(genSecond),
    .twoBytes(genTwo),
    .startBytePre(genStart)
  );

  // bus decode
  assign hitCfg = (paddr == `ADDR_CFG);
  assign hitTar = (paddr == `ADDR_TAR);
  assign hitSar = (paddr == `ADDR_SAR);
  assign hitCmd = (paddr == `ADDR_CMD);
  assign hitStat = (paddr == `ADDR_STAT);
  assign hitOn = (paddr == `ADDR_ON);
  assign mapped = hitCfg | hitTar | hitSar | hitCmd | hitStat | hitOn;
  assign apbDone = psel & penable & pready;
  assign wrDone = apbDone & pwrite & mapped;

  assign special = target[`TAR_SPECIAL];
  assign pick = target[`TAR_PICK];
  assign gcNow = special & ~pick;
  assign cmdIsRead = pwdata[`CMD_READ];

  // 7-bit slave mode only compares the low seven bits
  assign selfTarget = roleCfg[`CFG_SWIDE] ?
    (target[9:0] == ownResponderAddress) :
    (target[6:0] == ownResponderAddress[6:0]);
  assign loopback = selfTarget & ~special;

  assign abortGc = cmdIsRead & (gcMode | gcNow);
  // shared fifos: the first direction is kept while loopback lasts
  assign abortLoop = loopback & slaveEnable & loopDirSet &
    (cmdIsRead != loopDir);
  // no own slave to answer, so self-addressing is refused
  assign abortSelf = loopback & ~slaveEnable;

  assign cmdPush = wrDone & hitCmd & controllerOnSwitch & masterEnable;
  assign cmdAbort = cmdPush & (abortGc | abortLoop | abortSelf);
  assign abortClr = wrDone & hitStat & pwdata[`STAT_ABORT];

  assign startSeen = sclNow & sclPrev & sdaPrev & ~sdaNow;
  assign stopSeen = sclNow & sclPrev & ~sdaPrev & sdaNow;

  // apb handshake with one wait state so prdata comes from a flop
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel && penable && !pready) begin
        pslverr <= ~mapped;
        prdata <= next_prdata;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always @* begin
    next_prdata = 32'h00000000;
    if (!pwrite) begin
      if (hitCfg) begin
        next_prdata = {16'h0000, roleCfg & `CFG_MASK};
      end else if (hitTar) begin
        next_prdata = {16'h0000, target & `TAR_MASK};
      end else if (hitSar) begin
        next_prdata = {22'h000000, ownResponderAddress};
      end else if (hitStat) begin
        next_prdata[`STAT_ABORT] = transmitAbortFlag;
        next_prdata[`STAT_BUSY] = busBusy;
        next_prdata[`STAT_GC] = gcMode;
        next_prdata[`STAT_LOOP] = loopback;
      end else if (hitOn) begin
        next_prdata[0] = controllerOnSwitch;
      end
    end
  end

  // configuration registers
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      roleCfg <= `CFG_RST;
      target <= `TAR_RST;
      ownResponderAddress <= `SAR_RST;
      controllerOnSwitch <= 1'b0;
    end else if (wrDone) begin
      if (hitCfg) begin
        roleCfg <= pwdata[15:0] & `CFG_MASK;
      end
      // one write holds the address for repeated start bytes
      if (hitTar) begin
        target <= pwdata[15:0] & `TAR_MASK;
      end
      if (hitSar && !controllerOnSwitch) begin
        ownResponderAddress <= pwdata[9:0];
      end
      if (hitOn) begin
        controllerOnSwitch <= pwdata[0];
      end
    end
  end

  // role and speed outputs decoded from the stored fields
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      masterEnable <= 1'b1;
      slaveEnable <= 1'b0;
      restartEnable <= 1'b1;
      initiatorWide <= 1'b1;
      responderWide <= 1'b1;
      speedStd <= 1'b0;
      speedFast <= 1'b1;
      ownAddress <= `SAR_RST;
    end else begin
      masterEnable <= roleCfg[`CFG_MEN];
      slaveEnable <= ~roleCfg[`CFG_SLV_DIS];
      restartEnable <= roleCfg[`CFG_RESTART];
      initiatorWide <= roleCfg[`CFG_MWIDE];
      responderWide <= roleCfg[`CFG_SWIDE];
      // codes 0 and 3 select neither speed
      speedStd <= (roleCfg[`CFG_SPD_HI:`CFG_SPD_LO] ==
        `SPEED_STD);
      speedFast <= (roleCfg[`CFG_SPD_HI:`CFG_SPD_LO] ==
        `SPEED_FAST);
      ownAddress <= roleCfg[`CFG_SWIDE] ? ownResponderAddress :
        {3'b000, ownResponderAddress[6:0]};
    end
  end

  // command push toward the master engine
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cmdValid <= 1'b0;
      cmdRead <= 1'b0;
      cmdData <= 8'h00;
      headerFirst <= 8'h00;
      headerSecond <= 8'h00;
      headerTwoBytes <= 1'b0;
      headerStartByte <= 1'b0;
    end else begin
      cmdValid <= cmdPush & ~cmdAbort;
      if (cmdPush && !cmdAbort) begin
        cmdRead <= cmdIsRead;
        cmdData <= pwdata[7:0];
        headerFirst <= genFirst;
        headerSecond <= genSecond;
        headerTwoBytes <= genTwo;
        headerStartByte <= genStart;
      end
    end
  end

  // general call mode and loopback direction
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      gcMode <= 1'b0;
      loopDirSet <= 1'b0;
      loopDir <= 1'b0;
    end else begin
      if (wrDone && hitTar && !pwdata[`TAR_SPECIAL]) begin
        gcMode <= 1'b0;
      end else if (cmdPush && !cmdAbort && gcNow) begin
        gcMode <= 1'b1;
      end
      if ((wrDone && (hitTar || hitSar)) || !controllerOnSwitch) begin
        loopDirSet <= 1'b0;
      end else if (cmdPush && !cmdAbort && loopback) begin
        loopDirSet <= 1'b1;
        loopDir <= cmdIsRead;
      end
    end
  end

  // abort flag: a new abort wins over a clear in the same cycle
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      transmitAbortFlag <= 1'b0;
    end else if (cmdAbort) begin
      transmitAbortFlag <= 1'b1;
    end else if (abortClr) begin
      transmitAbortFlag <= 1'b0;
    end
  end

  // bus activity from start and stop seen on the synchronised pins
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
      busBusy <= 1'b0;
    end else begin
      sclPrev <= sclNow;
      sdaPrev <= sdaNow;
      if (startSeen) begin
        busBusy <= 1'b1;
      end else if (stopSeen) begin
        busBusy <= 1'b0;
      end
    end
  end
endmodule

// File: verification/i2c_cfg_sva.sv
// Purpose: assertions on role, speed and command header outputs
// Assumes: a write lands at the edge that samples pready high
// Notes: shadow copies of config and target feed the checks
`timescale 1ns/1ns
`include "i2c_cfg_consts.vh"
module i2c_cfg_sva (
  input wire clock,
  input wire arst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire masterEnable,
  input wire slaveEnable,
  input wire restartEnable,
  input wire initiatorWide,
  input wire responderWide,
  input wire speedStd,
  input wire speedFast,
  input wire [9:0] ownAddress,
  input wire cmdValid,
  input wire cmdRead,
  input wire [7:0] cmdData,
  input wire [7:0] headerFirst,
  input wire headerTwoBytes,
  input wire headerStartByte
);
  reg [15:0] cfgQ;
  reg [15:0] tarQ;
  wire apbDone = psel && penable && pready && pwrite;
  wire cfgWr = apbDone && paddr == `ADDR_CFG;
  wire cmdWr = apbDone && paddr == `ADDR_CMD;
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cfgQ <= `CFG_RST;
      tarQ <= `TAR_RST;
    end else begin
      if (cfgWr) cfgQ <= pwdata[15:0];
      if (apbDone && paddr == `ADDR_TAR) tarQ <= pwdata[15:0];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // outputs trail the register by one cycle
  sequence cfgTaken;
    cfgWr ##2 1'b1;
  endsequence
  a_role_bits: assert property (cfgTaken |->
    masterEnable == cfgQ[0] && slaveEnable == !cfgQ[6])
    else $error("role enables disagree with config");
  a_mode_bits: assert property (cfgTaken |->
    restartEnable == cfgQ[5] && initiatorWide == cfgQ[4]
    && responderWide == cfgQ[3]) else $error("mode bits wrong");
  a_speed_code: assert property (cfgTaken |->
    speedStd == (cfgQ[2:1] == `SPEED_STD)
    && speedFast == (cfgQ[2:1] == `SPEED_FAST)) else $error("speed wrong");
  a_cmd_bits: assert property (cmdValid |-> $past(cmdWr) &&
    cmdRead == $past(pwdata[8]) && cmdData == $past(pwdata[7:0]))
    else $error("command fields wrong");
  a_narrow_hdr: assert property (cmdValid && !initiatorWide
    && !tarQ[11] |-> headerFirst == {tarQ[6:0], cmdRead}
    && !headerTwoBytes) else $error("7-bit header wrong");
  a_gc_header: assert property (cmdValid && tarQ[11]
    && !tarQ[10] |-> headerFirst == `GC_ADDR && !cmdRead)
    else $error("general call header wrong");
  a_start_byte: assert property (cmdValid |->
    headerStartByte == (tarQ[11] && tarQ[10])) else $error("start byte");
  a_no_self: assert property (cmdValid && !tarQ[11] &&
    !responderWide && tarQ[6:0] == ownAddress[6:0] |-> slaveEnable)
    else $error("master sent to its own disabled slave");
endmodule
bind i2c_role_target_cfg i2c_cfg_sva i_sva (.clock, .arst_n, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .masterEnable, .slaveEnable,
  .restartEnable, .initiatorWide, .responderWide, .speedStd, .speedFast,
  .ownAddress, .cmdValid, .cmdRead, .cmdData, .headerFirst, .headerTwoBytes,
  .headerStartByte);

// File: verification/bus_peer.sv
// Purpose: far-side bus master making START and STOP on the pins
// Assumes: both lines idle high through pull-ups
// Notes: link clock stands still between frames
`timescale 1ns/1ns
module bus_peer (
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task frame_start();
    #200 sda = 1'b0;
    #200 scl = 1'b0;
  endtask
  task frame_stop();
    #200 scl = 1'b1;
    #200 sda = 1'b1;
  endtask
endmodule

// File: verification/test_i2c_role_target_cfg.sv
// Purpose: register, command and pin tests of the configuration block
// Assumes: apb slave answers within a bounded wait
// Notes: expected values are built from field positions
`timescale 1ns/1ns
`include "i2c_cfg_consts.vh"
module test_i2c_role_target_cfg;
  logic clock, arst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [31:0] paddr, pwdata, prdata, r;
  logic sclIn, sdaIn, masterEnable, slaveEnable, restartEnable;
  logic initiatorWide, responderWide, speedStd, speedFast, busBusy;
  logic [9:0] ownAddress;
  logic cmdValid, cmdRead, headerTwoBytes, headerStartByte;
  logic [7:0] cmdData, headerFirst, headerSecond;
  int failures, n_checks;
  i2c_role_target_cfg i_i2c_role_target_cfg (.clock, .arst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sclIn,
    .sdaIn, .masterEnable, .slaveEnable, .restartEnable, .initiatorWide,
    .responderWide, .speedStd, .speedFast, .ownAddress, .cmdValid, .cmdRead,
    .cmdData, .headerFirst, .headerSecond, .headerTwoBytes,
    .headerStartByte, .busBusy);
  bus_peer i_bus_peer (.scl(sclIn), .sda(sdaIn));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task chk(input [31:0] seen, input [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task xfer(input w, input [31:0] a, input [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // pready seen high ends this wait; the watchdog ends it only if pready never comes
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input [31:0] a, input [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd(input [31:0] a, input [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(r, exp);
  endtask
  task cmd(input [31:0] d, input v);
    wr(`ADDR_CMD, d);
    #1;
    chk(cmdValid, v);
  endtask
  // the flag is write-one-to-clear, so each check leaves it clear
  task abort_seen();
    xfer(1'b0, `ADDR_STAT, 32'h0);
    chk(r[6], 1'b1);
    wr(`ADDR_STAT, 32'h40);
  endtask
  task tally_and_finish();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    #1;
    chk({masterEnable, slaveEnable, restartEnable, initiatorWide,
      responderWide, speedStd, speedFast}, 7'h5d);
    rd(`ADDR_CFG, 32'h7d);
    rd(`ADDR_TAR, 32'h55);
    wr(`ADDR_CFG, 32'hffffffff);
    rd(`ADDR_CFG, 32'h7f);
    chk({masterEnable, slaveEnable, restartEnable, initiatorWide,
      responderWide, speedStd, speedFast}, 7'h5c);
    wr(`ADDR_TAR, 32'hffffffff);
    rd(`ADDR_TAR, 32'hfff);
    xfer(1'b0, 32'h50001400, 32'h0);
    chk(e, 1'b1);
    chk(r, 32'h0);
    for (int c = 0; c < 4; c++) begin
      wr(`ADDR_CFG, c << 1);
      @(posedge clock);
      #1;
      chk({speedStd, speedFast}, {c == 1, c == 2});
      chk({masterEnable, slaveEnable, restartEnable, initiatorWide,
        responderWide}, 5'h08);
    end
    wr(`ADDR_ON, 32'h1);
    wr(`ADDR_CFG, 32'h65);
    wr(`ADDR_TAR, 32'h12);
    cmd(32'h1a5, 1'b1);
    chk({headerFirst, cmdData, headerTwoBytes}, 17'h04b4a);
    wr(`ADDR_CFG, 32'h75);
    wr(`ADDR_TAR, 32'h2b4);
    cmd(32'h0, 1'b1);
    chk({headerFirst, headerSecond, headerTwoBytes}, 17'h1e969);
    wr(`ADDR_TAR, 32'h923);
    cmd(32'h11, 1'b1);
    chk({headerFirst, headerStartByte}, 9'h0);
    cmd(32'h100, 1'b0);
    abort_seen();
    cmd(32'h100, 1'b0);
    abort_seen();
    // start byte picked, special still set: general call mode stays
    wr(`ADDR_TAR, 32'hd23);
    cmd(32'h100, 1'b0);
    abort_seen();
    wr(`ADDR_TAR, 32'h523);
    cmd(32'h100, 1'b1);
    chk({headerFirst, headerSecond, headerStartByte}, 17'h1e646);
    chk(cmdRead, 1'b1);
    wr(`ADDR_TAR, 32'hc31);
    cmd(32'h7, 1'b1);
    cmd(32'h100, 1'b1);
    chk(headerStartByte, 1'b1);
    wr(`ADDR_CFG, 32'h65);
    wr(`ADDR_TAR, 32'h55);
    cmd(32'h1, 1'b0);
    abort_seen();
    wr(`ADDR_CFG, 32'h25);
    cmd(32'h1, 1'b1);
    cmd(32'h100, 1'b0);
    abort_seen();
    wr(`ADDR_SAR, 32'h3ff);
    rd(`ADDR_SAR, 32'h55);
    wr(`ADDR_ON, 32'h0);
    wr(`ADDR_SAR, 32'h1ab);
    rd(`ADDR_SAR, 32'h1ab);
    chk(ownAddress, 10'h02b);
    i_bus_peer.frame_start();
    repeat (6) @(posedge clock);
    #1;
    chk(busBusy, 1'b1);
    i_bus_peer.frame_stop();
    repeat (6) @(posedge clock);
    #1;
    chk(busBusy, 1'b0);
    tally_and_finish();
  end
endmodule
